// [vic_pkg.sv]
/*
 * Package of the vectored interrupt controller: data-memory addresses,
 * field positions, reset values and vectors of the two control registers.
 * Assumes an 8-bit data memory bus and a 14-bit vector address.
 */
package vic_pkg;

    // -------------------------------------------------------------------
    // Register addresses and widths
    // -------------------------------------------------------------------
    localparam int unsigned ADDR_W        = 8;
    localparam int unsigned DATA_W        = 8;
    localparam int unsigned VEC_W         = 14;
    localparam int unsigned NUM_SRC       = 5;
    localparam logic [7:0]  CTRL_LOW_ADDR  = 8'h0B;
    localparam logic [7:0]  CTRL_HIGH_ADDR = 8'h1E;

    // -------------------------------------------------------------------
    // Low control register fields
    // -------------------------------------------------------------------
    localparam int unsigned LOW_GIE_BIT   = 0;
    localparam int unsigned LOW_EXT_EN    = 1;
    localparam int unsigned LOW_T0_EN     = 2;
    localparam int unsigned LOW_EXT_FLAG  = 4;
    localparam int unsigned LOW_T0_FLAG   = 5;

    // -------------------------------------------------------------------
    // High control register fields
    // -------------------------------------------------------------------
    localparam int unsigned HIGH_T2_EN    = 0;
    localparam int unsigned HIGH_T3_EN    = 1;
    localparam int unsigned HIGH_PWM_EN   = 2;
    localparam int unsigned HIGH_T2_FLAG  = 4;
    localparam int unsigned HIGH_T3_FLAG  = 5;
    localparam int unsigned HIGH_PWM_FLAG = 6;

    // -------------------------------------------------------------------
    // Reset values (all interrupts disabled)
    // -------------------------------------------------------------------
    localparam logic [4:0]  ENABLE_RESET  = 5'h00;
    localparam logic [4:0]  FLAG_RESET    = 5'h00;
    localparam logic        GIE_RESET     = 1'b0;

    // -------------------------------------------------------------------
    // Source indices in priority order and their vectors
    // -------------------------------------------------------------------
    localparam int unsigned SRC_EXT = 0;
    localparam int unsigned SRC_T0  = 1;
    localparam int unsigned SRC_T2  = 2;
    localparam int unsigned SRC_T3  = 3;
    localparam int unsigned SRC_PWM = 4;
    localparam logic [13:0] VEC_EXT = 14'h0004;
    localparam logic [13:0] VEC_T0  = 14'h0008;
    localparam logic [13:0] VEC_T2  = 14'h0010;
    localparam logic [13:0] VEC_T3  = 14'h0014;
    localparam logic [13:0] VEC_PWM = 14'h0018;

endpackage

// [vic_prio_enc.sv]
/*
 * Fixed-priority picker: chooses the lowest-indexed active request and
 * returns its one-hot grant and program vector. Purely combinational.
 * Assumes source 0 has the highest priority.
 */
`timescale 1ns/1ps

module vic_prio_enc (
    input  wire logic [4:0]  req_i,
    output logic      [4:0]  grant_o,
    output logic      [13:0] vector_o,
    output logic             any_o
);

    // -------------------------------------------------------------------
    // Priority chain, highest first
    // -------------------------------------------------------------------
    always_comb begin
        grant_o  = 5'h00;
        vector_o = 14'h0000;
        if (req_i[vic_pkg::SRC_EXT]) begin
            grant_o[vic_pkg::SRC_EXT] = 1'b1;
            vector_o = vic_pkg::VEC_EXT;
        end else if (req_i[vic_pkg::SRC_T0]) begin
            grant_o[vic_pkg::SRC_T0] = 1'b1;
            vector_o = vic_pkg::VEC_T0;
        end else if (req_i[vic_pkg::SRC_T2]) begin
            grant_o[vic_pkg::SRC_T2] = 1'b1;
            vector_o = vic_pkg::VEC_T2;
        end else if (req_i[vic_pkg::SRC_T3]) begin
            grant_o[vic_pkg::SRC_T3] = 1'b1;
            vector_o = vic_pkg::VEC_T3;
        end else if (req_i[vic_pkg::SRC_PWM]) begin
            grant_o[vic_pkg::SRC_PWM] = 1'b1;
            vector_o = vic_pkg::VEC_PWM;
        end
    end

    assign any_o = |req_i;

endmodule

// [vic_ctrl.sv]
/*
 * Vectored interrupt controller: two data-memory control registers,
 * request flags, enables, fixed priority and the call request to the core.
 * Assumes the core performs the push and branch when call is pulsed,
 * reports stack-full, and pulses a return strobe on return-from-interrupt only.
 */
//
// Summary of operation
// - Servicing pushes PC plus extra address bit, then branches; nothing else saved.
// - Falling edge on external pin sets external flag, low register bit 4.
// - External pending, enabled, stack not full: call 04H, clear flag and global.
// - Timer 0 overflow sets timer 0 flag, low register bit 5.
// - Timer 0 pending and enabled, stack not full: call 08H, clear flag and global.
// - Timers 2 and 3 like timer 0; enables high bits 0/1, flags 4/5.
// - No further acknowledge until return-from-interrupt or software re-enables.
// - Return-from-interrupt sets global enable; plain return leaves it alone.
// - Requests are serviced at the next second clock phase pulse.
// - Fixed priority external, timer 0, 2, 3, PWM; global clear masks all.
// - Low register bit 0 is global enable, 1 enables.
// - Low bit 1 enables external, bit 2 timer 0; bits 3, 6, 7 unused.
// - High bit 2 enables PWM, bit 6 its flag; bits 3, 7 zero.
// - Control registers sit at data addresses 0BH and 1EH.
// - Flags stay until serviced or cleared by software; enable gates service.
// - Every source can wake the device from halt.
// - No acknowledge while the stack is full.
`timescale 1ns/1ps

module vic_ctrl (
    input  wire logic        core_clk_i,
    input  wire logic        reset_i,
    input  wire logic        clk_en_i,
    input  wire logic        ext_irq_n_i,
    input  wire logic        timer0_ovf_i,
    input  wire logic        timer2_ovf_i,
    input  wire logic        timer3_ovf_i,
    input  wire logic        pwm_dac_evt_i,
    input  wire logic        second_clock_phase_i,
    input  wire logic        stack_full_i,
    input  wire logic        return_from_interrupt_i,
    input  wire logic        mem_wr_i,
    input  wire logic [7:0]  mem_addr_i,
    input  wire logic [7:0]  mem_wdata_i,
    output logic      [7:0]  mem_rdata_o,
    output logic             irq_call_o,
    output logic      [13:0] irq_vector_o,
    output logic             wake_o
);

    // -------------------------------------------------------------------
    // State and internal signals
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {
        VIC_IDLE = 2'b01,
        VIC_CALL = 2'b10
    } vic_state_t;

    vic_state_t  state_reg;
    logic [4:0]  enable_reg;
    logic [4:0]  flag_reg;
    logic [4:0]  flag_next;
    logic        global_irq_enable_reg;
    logic        ext_sync1_reg;
    logic        ext_sync2_reg;
    logic        ext_prev_reg;
    logic        phase_prev_reg;
    logic [4:0]  set_evt;
    logic [4:0]  pending;
    logic [4:0]  grant;
    logic [13:0] vector;
    logic        any_req;
    logic        phase_rise;
    logic        take;
    logic        wr_low;
    logic        wr_high;
    logic [7:0]  rdata_next;

    // Address decode of the two control registers
    assign wr_low  = mem_wr_i && (mem_addr_i == vic_pkg::CTRL_LOW_ADDR);
    assign wr_high = mem_wr_i && (mem_addr_i == vic_pkg::CTRL_HIGH_ADDR);

    // -------------------------------------------------------------------
    // External pin synchroniser and falling-edge detect
    // -------------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ext_sync1_reg <= 1'b1;
            ext_sync2_reg <= 1'b1;
            ext_prev_reg  <= 1'b1;
        end else if (clk_en_i) begin
            ext_sync1_reg <= ext_irq_n_i;
            ext_sync2_reg <= ext_sync1_reg;
            ext_prev_reg  <= ext_sync2_reg;
        end
    end

    // Source events gathered in priority order
    assign set_evt[vic_pkg::SRC_EXT] = ext_prev_reg && !ext_sync2_reg;
    assign set_evt[vic_pkg::SRC_T0]  = timer0_ovf_i;
    assign set_evt[vic_pkg::SRC_T2]  = timer2_ovf_i;
    assign set_evt[vic_pkg::SRC_T3]  = timer3_ovf_i;
    assign set_evt[vic_pkg::SRC_PWM] = pwm_dac_evt_i;

    // -------------------------------------------------------------------
    // Sample point: rising edge of the second clock phase
    // -------------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            phase_prev_reg <= 1'b0;
        end else if (clk_en_i) begin
            phase_prev_reg <= second_clock_phase_i;
        end
    end

    assign phase_rise = second_clock_phase_i && !phase_prev_reg;

    // Enabled and pending sources, masked by global enable
    assign pending = flag_reg & enable_reg
                   & {5{global_irq_enable_reg}};

    vic_prio_enc u_prio (
        .req_i    (pending),
        .grant_o  (grant),
        .vector_o (vector),
        .any_o    (any_req)
    );

    // Acknowledge only on phase edge, with room on the stack
    assign take = (state_reg == VIC_IDLE) && phase_rise && any_req
                && !stack_full_i;

    // -------------------------------------------------------------------
    // Request flags: hardware set wins over clear
    // -------------------------------------------------------------------
    always_comb begin
        flag_next = flag_reg;
        if (wr_low) begin
            flag_next[vic_pkg::SRC_EXT] = mem_wdata_i[vic_pkg::LOW_EXT_FLAG];
            flag_next[vic_pkg::SRC_T0]  = mem_wdata_i[vic_pkg::LOW_T0_FLAG];
        end
        if (wr_high) begin
            flag_next[vic_pkg::SRC_T2]  = mem_wdata_i[vic_pkg::HIGH_T2_FLAG];
            flag_next[vic_pkg::SRC_T3]  = mem_wdata_i[vic_pkg::HIGH_T3_FLAG];
            flag_next[vic_pkg::SRC_PWM] =
                mem_wdata_i[vic_pkg::HIGH_PWM_FLAG];
        end
        if (take) begin
            flag_next = flag_next & ~grant;
        end
        flag_next = flag_next | set_evt;
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            flag_reg <= vic_pkg::FLAG_RESET;
        end else if (clk_en_i) begin
            flag_reg <= flag_next;
        end
    end

    // -------------------------------------------------------------------
    // Individual enables
    // -------------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            enable_reg <= vic_pkg::ENABLE_RESET;
        end else if (clk_en_i) begin
            if (wr_low) begin
                enable_reg[vic_pkg::SRC_EXT] <=
                    mem_wdata_i[vic_pkg::LOW_EXT_EN];
                enable_reg[vic_pkg::SRC_T0] <=
                    mem_wdata_i[vic_pkg::LOW_T0_EN];
            end
            if (wr_high) begin
                enable_reg[vic_pkg::SRC_T2] <=
                    mem_wdata_i[vic_pkg::HIGH_T2_EN];
                enable_reg[vic_pkg::SRC_T3] <=
                    mem_wdata_i[vic_pkg::HIGH_T3_EN];
                enable_reg[vic_pkg::SRC_PWM] <=
                    mem_wdata_i[vic_pkg::HIGH_PWM_EN];
            end
        end
    end

    // -------------------------------------------------------------------
    // Global enable: cleared on acknowledge, set by return or software
    // -------------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            global_irq_enable_reg <= vic_pkg::GIE_RESET;
        end else if (clk_en_i) begin
            if (take) begin
                global_irq_enable_reg <= 1'b0;
            end else if (return_from_interrupt_i) begin
                global_irq_enable_reg <= 1'b1;
            end else if (wr_low) begin
                global_irq_enable_reg <=
                    mem_wdata_i[vic_pkg::LOW_GIE_BIT];
            end
        end
    end

    // -------------------------------------------------------------------
    // Call handshake: one-cycle call pulse with vector
    // -------------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_reg    <= VIC_IDLE;
            irq_call_o   <= 1'b0;
            irq_vector_o <= 14'h0000;
        end else if (clk_en_i) begin
            case (state_reg)
                VIC_IDLE: begin
                    irq_call_o <= take;
                    if (take) begin
                        irq_vector_o <= vector;
                        state_reg    <= VIC_CALL;
                    end
                end
                VIC_CALL: begin
                    irq_call_o <= 1'b0;
                    state_reg  <= VIC_IDLE;
                end
                default: begin
                    irq_call_o <= 1'b0;
                    state_reg  <= VIC_IDLE;
                end
            endcase
        end
    end

    // -------------------------------------------------------------------
    // Wake request: any source event in the cycle, regardless of enables
    // -------------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            wake_o <= 1'b0;
        end else if (clk_en_i) begin
            wake_o <= |set_evt;
        end
    end

    // -------------------------------------------------------------------
    // Register read-back, unused bits zero
    // -------------------------------------------------------------------
    always_comb begin
        rdata_next = 8'h00;
        if (mem_addr_i == vic_pkg::CTRL_LOW_ADDR) begin
            rdata_next[vic_pkg::LOW_GIE_BIT]  = global_irq_enable_reg;
            rdata_next[vic_pkg::LOW_EXT_EN]   = enable_reg[vic_pkg::SRC_EXT];
            rdata_next[vic_pkg::LOW_T0_EN]    = enable_reg[vic_pkg::SRC_T0];
            rdata_next[vic_pkg::LOW_EXT_FLAG] = flag_reg[vic_pkg::SRC_EXT];
            rdata_next[vic_pkg::LOW_T0_FLAG]  = flag_reg[vic_pkg::SRC_T0];
        end else if (mem_addr_i == vic_pkg::CTRL_HIGH_ADDR) begin
            rdata_next[vic_pkg::HIGH_T2_EN]    = enable_reg[vic_pkg::SRC_T2];
            rdata_next[vic_pkg::HIGH_T3_EN]    = enable_reg[vic_pkg::SRC_T3];
            rdata_next[vic_pkg::HIGH_PWM_EN]   = enable_reg[vic_pkg::SRC_PWM];
            rdata_next[vic_pkg::HIGH_T2_FLAG]  = flag_reg[vic_pkg::SRC_T2];
            rdata_next[vic_pkg::HIGH_T3_FLAG]  = flag_reg[vic_pkg::SRC_T3];
            rdata_next[vic_pkg::HIGH_PWM_FLAG] = flag_reg[vic_pkg::SRC_PWM];
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            mem_rdata_o <= 8'h00;
        end else if (clk_en_i) begin
            mem_rdata_o <= rdata_next;
        end
    end

endmodule

// [vic_ctrl_monitor.sv]
/*
 * Checker for the interrupt controller: call pulse, vectors, masking,
 * register read-back and wake-up. Assumes the ports of vic_ctrl only.
 */
`timescale 1ns/1ps

module vic_ctrl_monitor (
    input wire logic        core_clk_i,
    input wire logic        reset_i,
    input wire logic        clk_en_i,
    input wire logic        ext_irq_n_i,
    input wire logic        timer0_ovf_i,
    input wire logic        pwm_dac_evt_i,
    input wire logic        second_clock_phase_i,
    input wire logic        stack_full_i,
    input wire logic        return_from_interrupt_i,
    input wire logic        mem_wr_i,
    input wire logic [7:0]  mem_addr_i,
    input wire logic [7:0]  mem_rdata_o,
    input wire logic        irq_call_o,
    input wire logic [13:0] irq_vector_o,
    input wire logic        wake_o
);
    // ---------------------------------------------------------------
    // Port properties
    // ---------------------------------------------------------------
    // Frozen clock enable holds state, so checking pauses with it
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i || !clk_en_i);

    a_call_single: assert property (irq_call_o |=> !irq_call_o)
        else $error("call pulse held longer than one cycle");
    a_full_blocks: assert property (stack_full_i |=> !irq_call_o)
        else $error("call while stack full");
    a_phase_take: assert property (irq_call_o |->
        $past(second_clock_phase_i) && !$past(second_clock_phase_i, 2))
        else $error("call not on a phase rise");
    a_vector_table: assert property (irq_call_o |-> irq_vector_o inside
        {14'h0004, 14'h0008, 14'h0010, 14'h0014, 14'h0018})
        else $error("call to unknown vector");
    a_vector_holds: assert property (!irq_call_o |-> $stable(irq_vector_o))
        else $error("vector moved without a call");
    a_masked_after: assert property (irq_call_o ##1
        (!return_from_interrupt_i && !mem_wr_i)[*4] |-> !irq_call_o)
        else $error("second call without re-enable");
    a_wake_timer: assert property ((timer0_ovf_i || pwm_dac_evt_i) |=> wake_o)
        else $error("no wake on source event");
    a_wake_pin: assert property ($fell(ext_irq_n_i) |-> ##[1:5] wake_o)
        else $error("no wake on pin edge");
    a_low_unused: assert property ($past(mem_addr_i) == 8'h0B |->
        mem_rdata_o[7:6] == 2'h0 && !mem_rdata_o[3])
        else $error("unused low bits read nonzero");
    a_high_unused: assert property ($past(mem_addr_i) == 8'h1E |->
        !mem_rdata_o[7] && !mem_rdata_o[3])
        else $error("zero high bits read nonzero");
    a_unmapped_zero: assert property (!($past(mem_addr_i) inside
        {8'h0B, 8'h1E}) |-> mem_rdata_o == 8'h00)
        else $error("unmapped address read nonzero");
endmodule

bind vic_ctrl vic_ctrl_monitor u_mon (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .clk_en_i(clk_en_i),
    .ext_irq_n_i(ext_irq_n_i), .timer0_ovf_i(timer0_ovf_i),
    .pwm_dac_evt_i(pwm_dac_evt_i), .stack_full_i(stack_full_i),
    .second_clock_phase_i(second_clock_phase_i), .mem_wr_i(mem_wr_i),
    .return_from_interrupt_i(return_from_interrupt_i),
    .mem_addr_i(mem_addr_i), .mem_rdata_o(mem_rdata_o),
    .irq_call_o(irq_call_o), .irq_vector_o(irq_vector_o), .wake_o(wake_o)
);

// [vic_core_model.sv]
/*
 * Behavioural core beside the controller: phase clock, stack depth and
 * the return strobe. Assumes the bench requests returns on ret_req_i.
 */
`timescale 1ns/1ps

module vic_core_model #(
    parameter int DEPTH = 8
) (
    input  wire logic core_clk_i,
    input  wire logic reset_i,
    input  wire logic irq_call_i,
    input  wire logic ret_req_i,
    output logic      second_clock_phase_o,
    output logic      stack_full_o,
    output logic      return_from_interrupt_o
);
    logic [1:0] phase_cnt_reg;
    int         depth_reg;
    logic       pop;

    // Pop only what was pushed
    assign pop = ret_req_i && depth_reg != 0;

    // Push on each call, pop on return; no calls of its own from a routine
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            phase_cnt_reg <= 2'h0;
            depth_reg <= 0;
            return_from_interrupt_o <= 1'b0;
        end else begin
            phase_cnt_reg <= phase_cnt_reg + 2'h1;
            return_from_interrupt_o <= pop;
            depth_reg <= depth_reg + int'(irq_call_i) - int'(pop);
        end
    end

    // Phase rises every fourth cycle; full once the last level is used
    assign second_clock_phase_o = phase_cnt_reg[1];
    assign stack_full_o = depth_reg >= DEPTH;
endmodule

// [vic_ctrl_bench.sv]
/*
 * Self-checking bench of the interrupt controller with a core model.
 * Assumes vic_ctrl, vic_core_model and the bound checker are compiled.
 */
`timescale 1ns/1ps

module vic_ctrl_bench;
    typedef struct packed {
        logic [4:0]  ev;
        logic [13:0] vec;
        logic [2:0]  srv;
    } vic_row_t;

    logic core_clk_i, reset_i, clk_en_i, ext_irq_n_i, ret_req;
    logic timer0_ovf_i, timer2_ovf_i, timer3_ovf_i, pwm_dac_evt_i;
    logic phase, full, ret_pulse, mem_wr_i, irq_call_o, wake_o;
    logic [7:0]  mem_addr_i, mem_wdata_i, mem_rdata_o;
    logic [13:0] irq_vector_o;
    logic [15:0] v, pre;
    int          n_mismatch, check_count;
    // Events per row: pwm, t3, t2, t0, ext from high bit down
    vic_row_t    rows [9] = '{
        '{5'h02, 14'h0008, 3'h1}, '{5'h01, 14'h0004, 3'h0},
        '{5'h04, 14'h0010, 3'h2}, '{5'h08, 14'h0014, 3'h3},
        '{5'h10, 14'h0018, 3'h4}, '{5'h1F, 14'h0004, 3'h0},
        '{5'h1C, 14'h0010, 3'h2}, '{5'h18, 14'h0014, 3'h3},
        '{5'h12, 14'h0008, 3'h1}};

    vic_ctrl u_dut (.core_clk_i(core_clk_i), .reset_i(reset_i),
        .clk_en_i(clk_en_i), .ext_irq_n_i(ext_irq_n_i),
        .timer0_ovf_i(timer0_ovf_i), .timer2_ovf_i(timer2_ovf_i),
        .timer3_ovf_i(timer3_ovf_i), .pwm_dac_evt_i(pwm_dac_evt_i),
        .second_clock_phase_i(phase), .stack_full_i(full),
        .return_from_interrupt_i(ret_pulse), .mem_wr_i(mem_wr_i),
        .mem_addr_i(mem_addr_i), .mem_wdata_i(mem_wdata_i),
        .mem_rdata_o(mem_rdata_o), .irq_call_o(irq_call_o),
        .irq_vector_o(irq_vector_o), .wake_o(wake_o));
    vic_core_model #(.DEPTH(2)) u_core (.core_clk_i(core_clk_i),
        .reset_i(reset_i), .irq_call_i(irq_call_o), .ret_req_i(ret_req),
        .second_clock_phase_o(phase), .stack_full_o(full),
        .return_from_interrupt_o(ret_pulse));

    // ---------------------------------------------------------------
    // Clock, tasks
    // ---------------------------------------------------------------
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] dat);
        @(negedge core_clk_i);
        mem_wr_i = 1'b1;
        mem_addr_i = a;
        mem_wdata_i = dat;
        @(negedge core_clk_i);
        mem_wr_i = 1'b0;
    endtask

    // Reads high then low register into one word
    task automatic regs(output logic [15:0] r);
        @(negedge core_clk_i);
        mem_addr_i = 8'h1E;
        @(negedge core_clk_i);
        r[15:8] = mem_rdata_o;
        mem_addr_i = 8'h0B;
        @(negedge core_clk_i);
        r[7:0] = mem_rdata_o;
        mem_addr_i = 8'h00;
    endtask

    task automatic wait_call(input logic [13:0] exp);
        int n;
        n = 0;
        while (irq_call_o !== 1'b1 && n < 40) begin
            @(negedge core_clk_i);
            n++;
        end
        if (n == 40) begin
            n_mismatch++;
            $display("Error call expected %h seen none", exp);
            end_of_test();
        end else begin
            check("vector", 16'(irq_vector_o), 16'(exp));
        end
    endtask

    task automatic quiet(input int n);
        repeat (n) begin
            @(negedge core_clk_i);
            check("idle call", 16'(irq_call_o), 16'h0000);
        end
    endtask

    task automatic ret();
        @(negedge core_clk_i);
        ret_req = 1'b1;
        @(negedge core_clk_i);
        ret_req = 1'b0;
    endtask

    task automatic ev_pulse(input logic [4:0] e);
        @(negedge core_clk_i);
        {pwm_dac_evt_i, timer3_ovf_i, timer2_ovf_i, timer0_ovf_i} = e[4:1];
        ext_irq_n_i = ~e[0];
        @(negedge core_clk_i);
        check("wake", 16'(wake_o), 16'(|e[4:1]));
        {pwm_dac_evt_i, timer3_ovf_i, timer2_ovf_i, timer0_ovf_i} = 4'h0;
        repeat (3) @(negedge core_clk_i);
        ext_irq_n_i = 1'b1;
    endtask

    function automatic logic [15:0] flags(input logic [4:0] e);
        return {1'b0, e[4:2], 4'h0, 2'h0, e[1:0], 4'h0};
    endfunction

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        {reset_i, clk_en_i, ext_irq_n_i} = 3'h7;
        {ret_req, timer0_ovf_i, timer2_ovf_i, timer3_ovf_i} = 4'h0;
        {pwm_dac_evt_i, mem_wr_i, mem_addr_i, mem_wdata_i} = 18'h00000;
        {n_mismatch, check_count} = 0;
        repeat (10) @(posedge core_clk_i);
        @(negedge core_clk_i);
        reset_i = 1'b0;
        regs(v);
        check("reset regs", v, 16'h0000);
        wr(8'h0C, 8'hFF);
        regs(v);
        check("unmapped write", v, 16'h0000);
        // Single and simultaneous sources: latch, mask, serve, clear
        foreach (rows[i]) begin
            wr(8'h1E, 8'h07);
            wr(8'h0B, 8'h06);
            ev_pulse(rows[i].ev);
            repeat (4) @(negedge core_clk_i);
            pre = 16'h0706 | flags(rows[i].ev);
            regs(v);
            check("flags", v, pre);
            quiet(8);
            wr(8'h0B, pre[7:0] | 8'h01);
            wait_call(rows[i].vec);
            regs(v);
            check("served", v, pre & ~flags(5'h01 << rows[i].srv));
            wr(8'h0B, 8'h00);
            wr(8'h1E, 8'h00);
            ret();
        end
        // Nesting by software, refusal while the stack is full
        wr(8'h1E, 8'h07);
        wr(8'h0B, 8'h06);
        ev_pulse(5'h0E);
        repeat (4) @(negedge core_clk_i);
        wr(8'h0B, 8'h27);
        wait_call(14'h0008);
        wr(8'h0B, 8'h07);
        wait_call(14'h0010);
        wr(8'h0B, 8'h07);
        quiet(12);
        ret();
        wait_call(14'h0014);
        regs(v);
        check("nest done", v, 16'h0706);
        wr(8'h0B, 8'h00);
        ret();
        ret();
        // Unused bits, then a software-set flag served on enable
        wr(8'h0B, 8'hF6);
        wr(8'h1E, 8'hFF);
        regs(v);
        check("unused bits", v, 16'h7736);
        quiet(8);
        wr(8'h0B, 8'h37);
        wait_call(14'h0004);
        // Reset in mid-run clears registers, stack and pending call
        @(negedge core_clk_i);
        reset_i = 1'b1;
        repeat (2) @(negedge core_clk_i);
        reset_i = 1'b0;
        regs(v);
        check("rerun regs", v, 16'h0000);
        quiet(4);
        end_of_test();
    end
endmodule
